// >>> tmr_regs.svh
// Register addresses, field positions and reset values for the timer control block
// Function
// RULE_01 - Control register 0xC8 page 0, fields, reset zero
// RULE_02 - Upper byte rollover sets high flag
// RULE_03 - Sixteen-bit wrap sets high flag
// RULE_04 - High flag raises interrupt when enabled
// RULE_05 - Lower byte rollover sets low flag
// RULE_06 - Flags cleared only by software write
// RULE_07 - Split selects two 8-bit reload counters
// RULE_08 - Split plus low enable: either byte interrupts
// RULE_09 - Run gates upper byte; split lower always runs
// RULE_10 - Capture copies count, sets high flag
// RULE_11 - Hardware set wins over same-cycle clear
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_CTRL_ADDR   8'hC8
`define TMR_CTRL_PAGE   4'h0
`define TMR_CTRL_RESET  8'h00
`define TMR_BIT_HFLAG   7
`define TMR_BIT_LFLAG   6
`define TMR_BIT_LIEN    5
`define TMR_BIT_CAPEN   4
`define TMR_BIT_SPLIT   3
`define TMR_BIT_RUN     2
`define TMR_BYTE_MAX    8'hFF
`define TMR_BYTE_ZERO   8'h00
`endif

// >>> tmr_pkg.sv
// Types shared by the timer control block
package tmr_pkg;
  typedef struct packed {
    logic       high_overflow_flag;
    logic       low_overflow_flag;
    logic       low_overflow_irq_enable;
    logic       capture_mode_enable;
    logic       split_mode_select;
    logic       run_control;
    logic [1:0] external_clock_select;
  } tmr_ctrl_s;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } tmr_count_s;
endpackage

// >>> tmr_top.sv
// Timer two control register, counter and overflow flags
`timescale 1ns/10ps
`default_nettype none
`include "tmr_regs.svh"
module tmr_top (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                SFR_WR,
  input  wire logic                SFR_RD,
  input  wire logic [7:0]          SFR_ADDR,
  input  wire logic [3:0]          SFR_PAGE,
  input  wire logic [7:0]          SFR_WDATA,
  input  wire logic                SFR_BIT_WR,
  input  wire logic [2:0]          SFR_BIT_SEL,
  input  wire logic                SFR_BIT_VAL,
  output logic [7:0]               SFR_RDATA,
  input  wire logic                TICK_UPPER,
  input  wire logic                TICK_LOWER,
  input  wire logic                CAPTURE_TRIG,
  input  wire logic                TIMER_IRQ_EN,
  input  wire tmr_pkg::tmr_count_s RELOAD,
  output tmr_pkg::tmr_count_s      COUNT,
  output tmr_pkg::tmr_count_s      CAPTURE_VALUE,
  output logic                     CAPTURE_STROBE,
  output tmr_pkg::tmr_ctrl_s       CTRL,
  output logic                     TIMER_IRQ
);
  import tmr_pkg::*;

  tmr_ctrl_s  ctrl_r,  ctrl_nxt;
  tmr_count_s cnt_r,   cnt_nxt;
  tmr_count_s cap_r,   cap_nxt;
  logic       cstb_r,  cstb_nxt;
  logic       hit;
  logic       up_ovf, lo_ovf, cap_evt;
  logic [7:0] wmask, wval, cur;

  assign hit = (SFR_ADDR == `TMR_CTRL_ADDR) && (SFR_PAGE == `TMR_CTRL_PAGE); // RULE_01

  always_comb begin
    cnt_nxt = cnt_r;
    up_ovf  = 1'b0;
    lo_ovf  = 1'b0;
    cap_evt = ctrl_r.capture_mode_enable && CAPTURE_TRIG; // RULE_10
    if (ctrl_r.split_mode_select) begin // RULE_07
      if (TICK_LOWER) begin // RULE_09
        if (cnt_r.lower == `TMR_BYTE_MAX) begin
          lo_ovf        = 1'b1; // RULE_05
          cnt_nxt.lower = RELOAD.lower;
        end else begin
          cnt_nxt.lower = cnt_r.lower + 8'h01;
        end
      end
      if (ctrl_r.run_control && TICK_UPPER) begin // RULE_09
        if (cnt_r.upper == `TMR_BYTE_MAX) begin
          up_ovf        = 1'b1; // RULE_02
          cnt_nxt.upper = RELOAD.upper;
        end else begin
          cnt_nxt.upper = cnt_r.upper + 8'h01;
        end
      end
    end else if (ctrl_r.run_control && TICK_LOWER) begin
      lo_ovf = (cnt_r.lower == `TMR_BYTE_MAX); // RULE_05
      if (cnt_r == {`TMR_BYTE_MAX, `TMR_BYTE_MAX}) begin
        up_ovf  = 1'b1; // RULE_03
        cnt_nxt = cap_evt ? cnt_r : RELOAD;
      end else begin
        cnt_nxt = tmr_count_s'(cnt_r + 16'h0001);
      end
    end
  end

  always_comb begin
    cur   = ctrl_r;
    wmask = 8'h00;
    wval  = 8'h00;
    if (hit && SFR_WR) begin
      wmask = 8'hFF;
      wval  = SFR_WDATA;
    end else if (hit && SFR_BIT_WR) begin
      wmask = 8'h01 << SFR_BIT_SEL;
      wval  = {8{SFR_BIT_VAL}};
    end
    cur      = (cur & ~wmask) | (wval & wmask); // RULE_06
    ctrl_nxt = tmr_ctrl_s'(cur);
    if (up_ovf || cap_evt) begin
      ctrl_nxt.high_overflow_flag = 1'b1; // RULE_11
    end
    if (lo_ovf) begin
      ctrl_nxt.low_overflow_flag = 1'b1; // RULE_11
    end
    cap_nxt  = cap_evt ? cnt_r : cap_r; // RULE_10
    cstb_nxt = cap_evt;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_r <= tmr_ctrl_s'(`TMR_CTRL_RESET); // RULE_01
      cnt_r  <= '0;
      cap_r  <= '0;
      cstb_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cnt_r  <= cnt_nxt;
      cap_r  <= cap_nxt;
      cstb_r <= cstb_nxt;
    end
  end

  always_comb begin
    SFR_RDATA = 8'h00;
    if (hit && SFR_RD) begin
      SFR_RDATA = ctrl_r;
    end
  end

  assign COUNT          = cnt_r;
  assign CAPTURE_VALUE  = cap_r;
  assign CAPTURE_STROBE = cstb_r;
  assign CTRL           = ctrl_r;
  // Level request; stays up while TIMER_IRQ_EN is high and an enabled flag is set
  assign TIMER_IRQ = TIMER_IRQ_EN && (ctrl_r.high_overflow_flag || // RULE_04
                     (ctrl_r.split_mode_select && ctrl_r.low_overflow_irq_enable && // RULE_08
                      ctrl_r.low_overflow_flag));
endmodule
`default_nettype wire

// >>> tmr_assertions.sv
// Port checks for the timer two control block
`timescale 1ns/10ps
`default_nettype none
module tmr_assertions (
  input wire logic                CLK,
  input wire logic                RST,
  input wire logic                SFR_WR,
  input wire logic                SFR_BIT_WR,
  input wire logic [7:0]          SFR_ADDR,
  input wire logic [3:0]          SFR_PAGE,
  input wire logic [7:0]          SFR_WDATA,
  input wire logic                TICK_LOWER,
  input wire logic                TIMER_IRQ_EN,
  input wire tmr_pkg::tmr_count_s COUNT,
  input wire tmr_pkg::tmr_ctrl_s  CTRL,
  input wire logic                TIMER_IRQ
);
  wire logic hit = SFR_WR && SFR_ADDR == 8'hC8 && SFR_PAGE == 4'h0;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_reset_zero: assert property ($fell(RST) |-> CTRL == 8'h00) else $error("rst");
  a_wr_land: assert property (hit |=> CTRL[5:0] == $past(SFR_WDATA[5:0])) else $error("w");
  a_wrap_flags: assert property (CTRL[3:2] == 2'h1 && TICK_LOWER && COUNT == 16'hFFFF
    |=> CTRL[7:6] == 2'h3) else $error("wrap");
  a_flag_hold: assert property (CTRL[7] && !hit && !SFR_BIT_WR |=> CTRL[7]) else $error("h");
  a_stop_hold: assert property (CTRL[3:2] == 2'h0 |=> $stable(COUNT)) else $error("run");
  a_irq_high: assert property (TIMER_IRQ_EN && CTRL[7] |-> TIMER_IRQ) else $error("irq");
  a_split_low: assert property (TIMER_IRQ_EN && CTRL[6:5] == 2'h3 && CTRL[3] |-> TIMER_IRQ)
    else $error("lirq");
  a_high_only: assert property (!CTRL[7] && !CTRL[3] |-> !TIMER_IRQ) else $error("src");
endmodule
bind tmr_top tmr_assertions u_chk (.*);
`default_nettype wire

// >>> tmr_cpu.sv
// Processor model on the special function register bus
`timescale 1ns/10ps
`default_nettype none
module tmr_cpu (
  input  wire logic       CLK,
  input  wire logic [7:0] SFR_RDATA,
  output logic            SFR_WR = 1'h0,
  output logic            SFR_RD = 1'h0,
  output logic [7:0]      SFR_ADDR = 8'h00,
  output logic [7:0]      SFR_WDATA = 8'h00
);
  logic [7:0] rdata_q;
  // Released address and data lines carry the complement and both strobes drop low, so stale values never pass as live
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK) {SFR_WR, SFR_RD, SFR_ADDR, SFR_WDATA} = {w, ~w, a, d};
    @(posedge CLK) rdata_q = SFR_RDATA;
    @(negedge CLK) {SFR_WR, SFR_RD, SFR_ADDR, SFR_WDATA} = {2'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the timer two control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tmr_pkg::*;
  logic       CLK = 1'h0, RST = 1'h1, SFR_WR, SFR_RD, SFR_BIT_WR = 1'h0, SFR_BIT_VAL = 1'h0;
  logic       TICK_UPPER = 1'h0, TICK_LOWER = 1'h0, CAPTURE_TRIG = 1'h0, TIMER_IRQ_EN = 1'h0;
  logic       CAPTURE_STROBE, TIMER_IRQ;
  logic [2:0] SFR_BIT_SEL = 3'h0;
  logic [3:0] SFR_PAGE = 4'h0;
  logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
  tmr_count_s RELOAD = 16'hFFFE, COUNT, CAPTURE_VALUE;
  tmr_ctrl_s  CTRL;
  int         bad_count = 0, tests_run = 0, cyc = 0;
  // Page, address, write data, expected readback; off-page and unmapped writes must not land
  logic [27:0] rows [4] = '{28'h0C95A00, 28'h0C8A5A5, 28'h1C8FFA5, 28'h0C80000};
  tmr_top dut (.*);
  tmr_cpu u_cpu (.*);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) $display("[FAIL] %0t %h %h", $time, g, e);
    bad_count += int'(g !== e);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0 && cyc < 80000) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #2.5 CLK = ~CLK;
  // Full 16-bit wrap takes 65536 ticks
  always @(posedge CLK) begin
    if (++cyc == 80000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge CLK);
    @(negedge CLK) RST = 1'h0;
    foreach (rows[i]) begin
      SFR_PAGE = rows[i][27:24];
      u_cpu.acc(1'h1, rows[i][23:16], rows[i][15:8]);
      SFR_PAGE = 4'h0;
      u_cpu.acc(1'h0, 8'hC8, 8'h00);
      chk(u_cpu.rdata_q, rows[i][7:0]);
    end
    {TIMER_IRQ_EN, TICK_LOWER} = 2'h3;
    u_cpu.acc(1'h1, 8'hC8, 8'h04);
    wait (CTRL[7] === 1'h1);
    repeat (4) @(negedge CLK);
    chk(CTRL, 8'hC4);
    chk({7'h0, TIMER_IRQ}, 8'h01);
    TICK_LOWER = 1'h0;
    u_cpu.acc(1'h1, 8'hC8, 8'h60);
    chk({7'h0, TIMER_IRQ}, 8'h00);
    u_cpu.acc(1'h1, 8'hC8, 8'h68);
    chk({7'h0, TIMER_IRQ}, 8'h01);
    RELOAD = 16'h1234;
    u_cpu.acc(1'h1, 8'hC8, 8'h0C);
    TICK_UPPER = 1'h1;
    wait (CTRL[7] === 1'h1);
    @(negedge CLK) TICK_UPPER = 1'h0;
    chk(CTRL, 8'h8C);
    chk(COUNT.upper, 8'h12);
    u_cpu.acc(1'h1, 8'hC8, 8'h10);
    // Capture lands in the same cycle as a write that clears the flag
    fork
      u_cpu.acc(1'h1, 8'hC8, 8'h10);
      begin
        @(negedge CLK) CAPTURE_TRIG = 1'h1;
        @(negedge CLK) CAPTURE_TRIG = 1'h0;
      end
    join
    chk(CTRL, 8'h90);
    chk({7'h0, CAPTURE_STROBE}, 8'h01);
    chk(CAPTURE_VALUE.upper, 8'h12);
    finish_test;
  end
endmodule
`default_nettype wire
